// ---- src/tb2_pkg.sv ----
// Purpose: Shared constants and types for the second general-purpose timer block
// Assumes: 16-bit special function register port, one system clock
// Notes: Control register layout is shared by both timers

package tb2_pkg;

  // Register byte addresses
  localparam logic [15:0] TB2_ADDR_AUX_CTL = 16'hff46;
  localparam logic [15:0] TB2_ADDR_CORE_CTL = 16'hff48;
  localparam logic [15:0] TB2_ADDR_AUX_TMR = 16'hfe46;
  localparam logic [15:0] TB2_ADDR_CORE_TMR = 16'hfe48;
  localparam logic [15:0] TB2_ADDR_CAP_RELOAD = 16'hfe4a;

  // Reset values
  localparam logic [15:0] TB2_RST_CTL = 16'h0000;
  localparam logic [15:0] TB2_RST_TMR = 16'h0000;

  // Writable bit masks; reserved bits read as zero
  localparam logic [15:0] TB2_CORE_CTL_MASK = 16'h87ff;
  localparam logic [15:0] TB2_AUX_CTL_MASK = 16'hf1ff;

  // Mode field codes
  localparam logic [2:0] TB2_MODE_TIMER = 3'h0;
  localparam logic [2:0] TB2_MODE_COUNTER = 3'h1;
  localparam logic [2:0] TB2_MODE_GATE_LO = 3'h2;
  localparam logic [2:0] TB2_MODE_GATE_HI = 3'h3;

  // Counter-mode edge selection (low two bits of input select)
  localparam logic [1:0] TB2_EDGE_RISE = 2'h1;
  localparam logic [1:0] TB2_EDGE_FALL = 2'h2;
  localparam logic [1:0] TB2_EDGE_BOTH = 2'h3;

  // Prescaler: least division is four system clocks
  localparam logic [8:0] TB2_PRESCALE_BASE = 9'h004;
  localparam int TB2_PRESCALE_W = 9;

  // Finest resolution at the reference clock
  localparam int TB2_REF_CLK_MHZ = 20;
  localparam int TB2_MIN_RES_NS = 200;
  localparam int TB2_MIN_RES_CYC = TB2_MIN_RES_NS * TB2_REF_CLK_MHZ / 1000;

  // Pin bundle indices
  localparam int TB2_PIN_CORE_IN = 0;
  localparam int TB2_PIN_CORE_DIR = 1;
  localparam int TB2_PIN_AUX_IN = 2;
  localparam int TB2_PIN_AUX_DIR = 3;
  localparam int TB2_PIN_CAP = 4;
  localparam int TB2_NPINS = 5;

  // Control word; hi holds reload enable (core) or capture controls (aux)
  typedef struct packed {
    logic [4:0] hi;
    logic otl;
    logic oe;
    logic ude;
    logic ud;
    logic run;
    logic [2:0] mode;
    logic [2:0] isel;
  } tb2_ctl_s;

  // Aux hi bits: [4] capture enable, [3] clear on capture, [2:1] capture edge
  localparam int TB2_HI_RELOAD = 4;
  localparam int TB2_HI_CAP_EN = 4;
  localparam int TB2_HI_CAP_CLR = 3;

  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } tb2_sfr_req_s;

endpackage

// ---- src/tb2_timer_block.sv ----
// Purpose: Second timer block: core up/down timer with toggle latch, auxiliary timer, capture/reload
// Assumes: Pins are asynchronous to clk_sys; the CPU reaches registers through the SFR port
// Notes: Pin events lag the pin by two clocks (two sync stages; edge stage only holds the previous sample)
// Functional notes
// - Core timer, auxiliary timer and one shared 16-bit capture/reload register.
// - Finest increment is one count per four system clocks.
// - Each timer has one input pin: gate in gated mode, count in counter mode.
// - CPU reads and overwrites both timer values any time; both count up or down.
// - Toggle latch (control bit 10) flips on every core wrap; software may set it.
// - Output enable (bit 9) puts toggle latch on output pin; otherwise output is low.
// - Reload enable (bit 15) loads core timer from capture/reload on wrap.
// - Capture pin edge copies auxiliary timer into capture/reload, optionally clearing it.
// - Toggle latch edges from core wraps can clock the auxiliary timer.
// - Core timer counts only while run bit 6 is set; otherwise holds.
// - Gated mode counts only with run set and gate pin at active level.
// - Mode 000 timer, 001 counter, 010 gate low, 011 gate high; 1xx idle.
// - Input select is prescaler in timer modes and edge select in counter mode.
// - Without external direction, direction bit alone: 0 up, 1 down.
// - With external direction, pin high means down; direction bit inverts it.
// - Direction changes take effect whether running or stopped.
// - Counter mode select 001 rise, 010 fall, 011 both, 000 off; 1xx takes toggle latch edges on aux, idle on core.
// - Timer mode prescaler is 4 times two to the input select.

`timescale 1ns/1ps
`default_nettype none

module tb2_timer_block (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire tb2_pkg::tb2_sfr_req_s sfr_req,
  output logic [15:0] sfr_rdata,
  input wire logic core_input_pin,
  input wire logic core_direction_pin,
  input wire logic aux_input_pin,
  input wire logic aux_direction_pin,
  input wire logic capture_input_pin,
  output logic toggle_output_pin
);
  import tb2_pkg::*;

  // Elaboration guard: base divider must give the finest resolution
  if (TB2_MIN_RES_CYC != int'(TB2_PRESCALE_BASE)) begin : g_bad_res
    $error("Prescaler base does not match finest resolution");
  end

  // Reset release synchroniser
  logic rst_m_q;
  logic rst_s_n;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_q <= 1'b0;
      rst_s_n <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_n <= rst_m_q;
    end
  end

  // Pin synchronisers; third stage only feeds edge detection
  logic [TB2_NPINS-1:0] pin_m_q;
  logic [TB2_NPINS-1:0] pin_s_q;
  logic [TB2_NPINS-1:0] pin_p_q;
  wire [TB2_NPINS-1:0] pin_raw = {capture_input_pin, aux_direction_pin, aux_input_pin,
                                  core_direction_pin, core_input_pin};
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
      pin_p_q <= '0;
    end else begin
      pin_m_q <= pin_raw;
      pin_s_q <= pin_m_q;
      pin_p_q <= pin_s_q;
    end
  end
  wire [TB2_NPINS-1:0] pin_rise = pin_s_q & ~pin_p_q;
  wire [TB2_NPINS-1:0] pin_fall = ~pin_s_q & pin_p_q;

  // Registers
  tb2_ctl_s core_ctl_q;
  tb2_ctl_s core_ctl_d;
  tb2_ctl_s aux_ctl_q;
  logic [15:0] core_q;
  logic [15:0] core_d;
  logic [15:0] aux_q;
  logic [15:0] aux_d;
  logic [15:0] cap_reload_q;
  logic [15:0] cap_reload_d;
  logic [TB2_PRESCALE_W-1:0] pre_q;
  logic [15:0] rdata_q;
  logic out_q;

  // Address decode
  wire wr_core_ctl = sfr_req.wr && (sfr_req.addr == TB2_ADDR_CORE_CTL);
  wire wr_aux_ctl = sfr_req.wr && (sfr_req.addr == TB2_ADDR_AUX_CTL);
  wire wr_core = sfr_req.wr && (sfr_req.addr == TB2_ADDR_CORE_TMR);
  wire wr_aux = sfr_req.wr && (sfr_req.addr == TB2_ADDR_AUX_TMR);
  wire wr_cap_reload = sfr_req.wr && (sfr_req.addr == TB2_ADDR_CAP_RELOAD);

  // Prescaler tick: low (2+isel) bits all ones; 4<<7 wraps to 0 giving mask 1ff
  function automatic logic pre_tick(input logic [2:0] isel, input logic [TB2_PRESCALE_W-1:0] cnt);
    logic [TB2_PRESCALE_W-1:0] mask;
    mask = TB2_PRESCALE_W'((TB2_PRESCALE_BASE << isel) - 9'h001);
    return (cnt & mask) == mask;
  endfunction

  // Count enable shared by both timers
  function automatic logic cnt_en(input tb2_ctl_s c, input logic gate, input logic rise,
                                  input logic fall, input logic trise, input logic tfall,
                                  input logic allow_tl, input logic [TB2_PRESCALE_W-1:0] cnt);
    logic r;
    logic er;
    logic ef;
    r = 1'b0;
    er = c.isel[2] ? (allow_tl & trise) : rise;
    ef = c.isel[2] ? (allow_tl & tfall) : fall;
    case (c.mode)
      TB2_MODE_TIMER: r = pre_tick(c.isel, cnt);
      TB2_MODE_COUNTER: begin
        case (c.isel[1:0])
          TB2_EDGE_RISE: r = er;
          TB2_EDGE_FALL: r = ef;
          TB2_EDGE_BOTH: r = er | ef;
          default: r = 1'b0;
        endcase
      end
      TB2_MODE_GATE_LO: r = pre_tick(c.isel, cnt) & ~gate;
      TB2_MODE_GATE_HI: r = pre_tick(c.isel, cnt) & gate;
      default: r = 1'b0;
    endcase
    return c.run & r;
  endfunction

  // Direction: pin selects when enabled, direction bit inverts; applies live
  wire core_down = core_ctl_q.ude ? (pin_s_q[TB2_PIN_CORE_DIR] ^ core_ctl_q.ud) : core_ctl_q.ud;
  wire aux_down = aux_ctl_q.ude ? (pin_s_q[TB2_PIN_AUX_DIR] ^ aux_ctl_q.ud) : aux_ctl_q.ud;

  // Core counting and wrap
  wire core_en = cnt_en(core_ctl_q, pin_s_q[TB2_PIN_CORE_IN], pin_rise[TB2_PIN_CORE_IN],
                        pin_fall[TB2_PIN_CORE_IN], 1'b0, 1'b0, 1'b0, pre_q);
  wire core_wrap = core_en && (core_down ? (core_q == 16'h0000) : (core_q == 16'hffff));
  wire [15:0] core_step = core_down ? (core_q - 16'h0001) : (core_q + 16'h0001);
  wire core_reload = core_wrap && core_ctl_q.hi[TB2_HI_RELOAD];

  // Only hardware toggles clock the auxiliary timer, never software writes
  wire tl_rise = core_wrap && !core_ctl_q.otl;
  wire tl_fall = core_wrap && core_ctl_q.otl;

  // Auxiliary counting
  wire aux_en = cnt_en(aux_ctl_q, pin_s_q[TB2_PIN_AUX_IN], pin_rise[TB2_PIN_AUX_IN],
                       pin_fall[TB2_PIN_AUX_IN], tl_rise, tl_fall, 1'b1, pre_q);
  wire [15:0] aux_step = aux_down ? (aux_q - 16'h0001) : (aux_q + 16'h0001);

  // Capture trigger on selected edge of capture pin
  wire [1:0] cap_sel = aux_ctl_q.hi[2:1];
  wire cap_edge = (cap_sel[0] & pin_rise[TB2_PIN_CAP]) | (cap_sel[1] & pin_fall[TB2_PIN_CAP]);
  wire cap_evt = aux_ctl_q.hi[TB2_HI_CAP_EN] && cap_edge;

  // Next-state selection; software writes win over counting
  always_comb begin
    core_ctl_d = wr_core_ctl ? tb2_ctl_s'(sfr_req.wdata & TB2_CORE_CTL_MASK) : core_ctl_q;
    core_ctl_d.otl = core_ctl_d.otl ^ core_wrap;
    core_d = core_q;
    if (wr_core) begin
      core_d = sfr_req.wdata;
    end else if (core_reload) begin
      core_d = cap_reload_q;
    end else if (core_en) begin
      core_d = core_step;
    end
    aux_d = aux_q;
    if (wr_aux) begin
      aux_d = sfr_req.wdata;
    end else if (cap_evt && aux_ctl_q.hi[TB2_HI_CAP_CLR]) begin
      aux_d = 16'h0000;
    end else if (aux_en) begin
      aux_d = aux_step;
    end
    // Hardware capture wins over a software write in the same cycle
    cap_reload_d = cap_evt ? aux_q : (wr_cap_reload ? sfr_req.wdata : cap_reload_q);
  end

  // Read mux; unmapped addresses read zero
  logic [15:0] rd_mux;
  assign rd_mux = (sfr_req.addr == TB2_ADDR_CORE_CTL) ? 16'(core_ctl_q) :
                  (sfr_req.addr == TB2_ADDR_AUX_CTL) ? 16'(aux_ctl_q) :
                  (sfr_req.addr == TB2_ADDR_CORE_TMR) ? core_q :
                  (sfr_req.addr == TB2_ADDR_AUX_TMR) ? aux_q :
                  (sfr_req.addr == TB2_ADDR_CAP_RELOAD) ? cap_reload_q : 16'h0000;

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      core_ctl_q <= tb2_ctl_s'(TB2_RST_CTL);
      aux_ctl_q <= tb2_ctl_s'(TB2_RST_CTL);
      core_q <= TB2_RST_TMR;
      aux_q <= TB2_RST_TMR;
      cap_reload_q <= TB2_RST_TMR;
      pre_q <= '0;
    end else begin
      core_ctl_q <= core_ctl_d;
      if (wr_aux_ctl) begin
        aux_ctl_q <= tb2_ctl_s'(sfr_req.wdata & TB2_AUX_CTL_MASK);
      end
      core_q <= core_d;
      aux_q <= aux_d;
      cap_reload_q <= cap_reload_d;
      pre_q <= pre_q + 9'h001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      rdata_q <= 16'h0000;
      out_q <= 1'b0;
    end else begin
      if (sfr_req.rd) begin
        rdata_q <= rd_mux;
      end
      out_q <= core_ctl_q.oe & core_ctl_q.otl;
    end
  end

  assign sfr_rdata = rdata_q;
  assign toggle_output_pin = out_q;

  // Stopped timer keeps its value
  property p_run_hold;
    @(posedge clk_sys) disable iff (!rst_s_n)
    (!core_ctl_q.run && !wr_core) |=> (core_q == $past(core_q));
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("Core timer moved while stopped");

  // Fastest prescale gives at most one count per four clocks
  property p_tick_space;
    @(posedge clk_sys) disable iff (!rst_s_n)
    (core_en && core_ctl_q.mode == TB2_MODE_TIMER && core_ctl_q.isel == 3'h0) |=> !core_en [*3];
  endproperty
  a_tick_space: assert property (p_tick_space) else $error("Core ticks closer than four clocks");

  // Wrap flips the toggle latch
  property p_toggle;
    @(posedge clk_sys) disable iff (!rst_s_n)
    (core_wrap && !wr_core_ctl) |=> (core_ctl_q.otl != $past(core_ctl_q.otl));
  endproperty
  a_toggle: assert property (p_toggle) else $error("Toggle latch did not flip on wrap");

  // Disabled output stays low
  property p_out_off;
    @(posedge clk_sys) disable iff (!rst_s_n)
    (!core_ctl_q.oe) |=> !toggle_output_pin;
  endproperty
  a_out_off: assert property (p_out_off) else $error("Output pin driven while disabled");

  // Wrap with reload enabled loads the capture/reload value
  property p_reload;
    @(posedge clk_sys) disable iff (!rst_s_n)
    (core_wrap && core_ctl_q.hi[TB2_HI_RELOAD] && !wr_core) |=> (core_q == $past(cap_reload_q));
  endproperty
  a_reload: assert property (p_reload) else $error("Core timer not reloaded on wrap");

  // Capture copies the auxiliary value
  property p_capture;
    @(posedge clk_sys) disable iff (!rst_s_n)
    cap_evt |=> (cap_reload_q == $past(aux_q));
  endproperty
  a_capture: assert property (p_capture) else $error("Capture register missed auxiliary value");

  // Software down direction decrements
  property p_dir_down;
    @(posedge clk_sys) disable iff (!rst_s_n)
    (core_en && !core_ctl_q.ude && core_ctl_q.ud && !wr_core && !core_wrap) |=>
      (core_q == $past(core_q) - 16'h0001);
  endproperty
  a_dir_down: assert property (p_dir_down) else $error("Core timer did not count down");

  // Inactive gate blocks counting
  property p_gate;
    @(posedge clk_sys) disable iff (!rst_s_n)
    (core_ctl_q.mode == TB2_MODE_GATE_HI && !pin_s_q[TB2_PIN_CORE_IN]) |-> !core_en;
  endproperty
  a_gate: assert property (p_gate) else $error("Core timer counted with gate inactive");

  // Upward wrap lands on zero
  property p_wrap_up;
    @(posedge clk_sys) disable iff (!rst_s_n)
    (core_en && !core_down && core_q == 16'hffff && !core_ctl_q.hi[TB2_HI_RELOAD] && !wr_core) |=>
      (core_q == 16'h0000);
  endproperty
  a_wrap_up: assert property (p_wrap_up) else $error("Core timer did not wrap to zero");

  // Direction pin high with direction bit clear counts down
  property p_ext_down;
    @(posedge clk_sys) disable iff (!rst_s_n)
    (core_en && core_ctl_q.ude && !core_ctl_q.ud && pin_s_q[TB2_PIN_CORE_DIR] && !wr_core && !core_wrap) |=>
      (core_q == $past(core_q) - 16'h0001);
  endproperty
  a_ext_down: assert property (p_ext_down) else $error("Core timer ignored direction pin");

  // Counter mode with no edge selected never counts
  property p_cnt_off;
    @(posedge clk_sys) disable iff (!rst_s_n)
    (core_ctl_q.mode == TB2_MODE_COUNTER && core_ctl_q.isel == 3'h0) |-> !core_en;
  endproperty
  a_cnt_off: assert property (p_cnt_off) else $error("Core timer counted with no edge selected");

endmodule

`default_nettype wire

// ---- bench/tb2_pin_model.sv ----
// Purpose: Pin-side model for gate, count, direction and capture inputs
// Assumes: Bench asks for levels; model moves pins at the falling edge
// Notes: Levels stand until the bench asks again, no glitches
`timescale 1ns/1ps
`default_nettype none
module tb2_pin_model (
  input wire logic clk_sys,
  input wire logic [4:0] pin_want,
  output logic core_input_pin,
  output logic core_direction_pin,
  output logic aux_input_pin,
  output logic aux_direction_pin,
  output logic capture_input_pin
);
  import tb2_pkg::*;
  logic [4:0] lvl_q = 5'h00;
  // Off the sampling edge, so sync flops never race the change
  always @(negedge clk_sys) begin
    lvl_q <= pin_want;
  end
  assign core_input_pin = lvl_q[TB2_PIN_CORE_IN];
  assign core_direction_pin = lvl_q[TB2_PIN_CORE_DIR];
  assign aux_input_pin = lvl_q[TB2_PIN_AUX_IN];
  assign aux_direction_pin = lvl_q[TB2_PIN_AUX_DIR];
  assign capture_input_pin = lvl_q[TB2_PIN_CAP];
endmodule
`default_nettype wire

// ---- bench/tb2_timer_block_tb_top.sv ----
// Purpose: Self-checking bench for the second timer block
// Assumes: Inputs move at the falling edge; pins held 6 clocks per level
// Notes: Rates measured over whole prescaler periods, so phase never matters
`timescale 1ns/1ps
`default_nettype none
module tb2_timer_block_tb_top;
  import tb2_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  tb2_sfr_req_s sfr_req = '0;
  logic [4:0] pin_want = 5'h00;
  logic [15:0] sfr_rdata;
  logic toggle_output_pin;
  logic cin, cdir, ain, adir, cap;
  int fail_count = 0;
  int total_checks = 0;
  logic [15:0] rv, a, d;
  tb2_pin_model u_pins (.clk_sys(clk_sys), .pin_want(pin_want), .core_input_pin(cin),
    .core_direction_pin(cdir), .aux_input_pin(ain), .aux_direction_pin(adir), .capture_input_pin(cap));
  tb2_timer_block dut (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .core_input_pin(cin), .core_direction_pin(cdir), .aux_input_pin(ain), .aux_direction_pin(adir),
    .capture_input_pin(cap), .toggle_output_pin(toggle_output_pin));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks=%0d failures=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // One access per call; strobe dropped a full cycle before the next
  task automatic sfr(input logic wr, input logic [15:0] ad, input logic [15:0] wd);
    @(negedge clk_sys);
    sfr_req.addr = ad;
    sfr_req.wdata = wd;
    sfr_req.wr = wr;
    sfr_req.rd = !wr;
    @(negedge clk_sys);
    sfr_req.wr = 1'b0;
    sfr_req.rd = 1'b0;
    rv = sfr_rdata;
  endtask
  // Core timer advance over n edges
  task automatic span(input int n);
    sfr(1'b0, TB2_ADDR_CORE_TMR, 16'h0000);
    a = rv;
    repeat (n - 2) @(negedge clk_sys);
    sfr(1'b0, TB2_ADDR_CORE_TMR, 16'h0000);
    d = rv - a;
  endtask
  task automatic t_regs;
    sfr(1'b0, TB2_ADDR_CORE_CTL, 16'h0000);
    check(rv, 16'h0000);
    sfr(1'b0, 16'hfe40, 16'h0000);
    check(rv, 16'h0000);
    sfr(1'b1, TB2_ADDR_CORE_CTL, 16'hffbf);
    sfr(1'b0, TB2_ADDR_CORE_CTL, 16'h0000);
    check(rv, 16'h87bf);
    check({15'h0000, toggle_output_pin}, 16'h0001);
    sfr(1'b1, TB2_ADDR_CORE_TMR, 16'ha5c3);
    sfr(1'b0, TB2_ADDR_CORE_TMR, 16'h0000);
    check(rv, 16'ha5c3);
    sfr(1'b1, TB2_ADDR_CORE_CTL, 16'h0000);
    $display("t_regs done");
  endtask
  task automatic t_timer;
    sfr(1'b1, TB2_ADDR_CORE_CTL, 16'h0040);
    span(40);
    check(d, 16'h000a);
    sfr(1'b1, TB2_ADDR_CORE_CTL, 16'h0042);
    span(160);
    check(d, 16'h000a);
    sfr(1'b1, TB2_ADDR_CORE_CTL, 16'h0000);
    span(40);
    check(d, 16'h0000);
    $display("t_timer done");
  endtask
  task automatic t_dir;
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      pin_want[TB2_PIN_CORE_DIR] = c[0];
      sfr(1'b1, TB2_ADDR_CORE_CTL, {7'h00, c[2], c[1], 7'h40});
      repeat (4) @(negedge clk_sys);
      span(40);
      check(d, (c[2] ? c[1] ^ c[0] : c[1]) ? 16'hfff6 : 16'h000a);
    end
    pin_want[TB2_PIN_CORE_DIR] = 1'b0;
    $display("t_dir done");
  endtask
  task automatic t_wrap;
    sfr(1'b1, TB2_ADDR_AUX_TMR, 16'h0000);
    sfr(1'b1, TB2_ADDR_AUX_CTL, 16'h004f);
    sfr(1'b1, TB2_ADDR_CORE_TMR, 16'h0003);
    sfr(1'b1, TB2_ADDR_CORE_CTL, 16'h02c0);
    repeat (20) @(negedge clk_sys);
    sfr(1'b0, TB2_ADDR_CORE_CTL, 16'h0000);
    check({15'h0000, rv[10]}, 16'h0001);
    check({15'h0000, toggle_output_pin}, 16'h0001);
    sfr(1'b0, TB2_ADDR_CORE_TMR, 16'h0000);
    check({8'h00, rv[15:8]}, 16'h00ff);
    sfr(1'b1, TB2_ADDR_CORE_CTL, 16'h0400);
    sfr(1'b0, TB2_ADDR_AUX_TMR, 16'h0000);
    check(rv, 16'h0001);
    check({15'h0000, toggle_output_pin}, 16'h0000);
    // Software clear of the latch must not clock the aux timer
    sfr(1'b1, TB2_ADDR_CORE_CTL, 16'h0000);
    sfr(1'b0, TB2_ADDR_AUX_TMR, 16'h0000);
    check(rv, 16'h0001);
    sfr(1'b1, TB2_ADDR_CAP_RELOAD, 16'h1234);
    sfr(1'b1, TB2_ADDR_CORE_TMR, 16'hfffd);
    sfr(1'b1, TB2_ADDR_CORE_CTL, 16'h8040);
    repeat (20) @(negedge clk_sys);
    sfr(1'b0, TB2_ADDR_CORE_TMR, 16'h0000);
    check({8'h00, rv[15:8]}, 16'h0012);
    sfr(1'b0, TB2_ADDR_AUX_TMR, 16'h0000);
    check(rv, 16'h0002);
    sfr(1'b1, TB2_ADDR_CORE_CTL, 16'h0000);
    sfr(1'b1, TB2_ADDR_AUX_CTL, 16'h0000);
    $display("t_wrap done");
  endtask
  task automatic t_counter;
    logic [15:0] ctl[6] = '{16'h0048, 16'h0049, 16'h004a, 16'h004b, 16'h004c, 16'h0061};
    logic [15:0] ex[6] = '{16'h0000, 16'h0003, 16'h0003, 16'h0006, 16'h0000, 16'h0000};
    for (int i = 0; i < 6; i++) begin
      sfr(1'b1, TB2_ADDR_CORE_CTL, ctl[i]);
      sfr(1'b0, TB2_ADDR_CORE_TMR, 16'h0000);
      a = rv;
      repeat (3) begin
        pin_want[TB2_PIN_CORE_IN] = 1'b1;
        repeat (6) @(negedge clk_sys);
        pin_want[TB2_PIN_CORE_IN] = 1'b0;
        repeat (6) @(negedge clk_sys);
      end
      sfr(1'b0, TB2_ADDR_CORE_TMR, 16'h0000);
      check(rv - a, ex[i]);
    end
    $display("t_counter done");
  endtask
  task automatic t_gate;
    logic [15:0] ctl[5] = '{16'h0058, 16'h0058, 16'h0050, 16'h0050, 16'h0018};
    logic gp[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    logic [15:0] ex[5] = '{16'h000a, 16'h0000, 16'h000a, 16'h0000, 16'h0000};
    for (int i = 0; i < 5; i++) begin
      pin_want[TB2_PIN_CORE_IN] = gp[i];
      sfr(1'b1, TB2_ADDR_CORE_CTL, ctl[i]);
      repeat (4) @(negedge clk_sys);
      span(40);
      check(d, ex[i]);
    end
    pin_want[TB2_PIN_CORE_IN] = 1'b0;
    sfr(1'b1, TB2_ADDR_CORE_CTL, 16'h0000);
    $display("t_gate done");
  endtask
  task automatic t_capture;
    sfr(1'b1, TB2_ADDR_AUX_CTL, 16'hd000);
    sfr(1'b1, TB2_ADDR_AUX_TMR, 16'h0055);
    pin_want[TB2_PIN_CAP] = 1'b1;
    repeat (6) @(negedge clk_sys);
    sfr(1'b0, TB2_ADDR_CAP_RELOAD, 16'h0000);
    check(rv, 16'h0055);
    sfr(1'b0, TB2_ADDR_AUX_TMR, 16'h0000);
    check(rv, 16'h0000);
    sfr(1'b1, TB2_ADDR_AUX_CTL, 16'h9000);
    sfr(1'b1, TB2_ADDR_AUX_TMR, 16'h0066);
    pin_want[TB2_PIN_CAP] = 1'b0;
    repeat (6) @(negedge clk_sys);
    pin_want[TB2_PIN_CAP] = 1'b1;
    repeat (6) @(negedge clk_sys);
    sfr(1'b0, TB2_ADDR_CAP_RELOAD, 16'h0000);
    check(rv, 16'h0066);
    sfr(1'b0, TB2_ADDR_AUX_TMR, 16'h0000);
    check(rv, 16'h0066);
    $display("t_capture done");
  endtask
  // Aux counter on its own pin, direction from its own pin
  task automatic t_aux;
    pin_want[TB2_PIN_AUX_DIR] = 1'b1;
    sfr(1'b1, TB2_ADDR_AUX_TMR, 16'h0010);
    sfr(1'b1, TB2_ADDR_AUX_CTL, 16'h0149);
    repeat (3) begin
      pin_want[TB2_PIN_AUX_IN] = 1'b1;
      repeat (6) @(negedge clk_sys);
      pin_want[TB2_PIN_AUX_IN] = 1'b0;
      repeat (6) @(negedge clk_sys);
    end
    sfr(1'b0, TB2_ADDR_AUX_TMR, 16'h0000);
    check(rv, 16'h000d);
    sfr(1'b1, TB2_ADDR_AUX_CTL, 16'h0000);
    pin_want[TB2_PIN_AUX_DIR] = 1'b0;
    $display("t_aux done");
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    t_regs();
    t_timer();
    t_dir();
    t_wrap();
    t_counter();
    t_gate();
    t_capture();
    t_aux();
    finish_test();
  end
endmodule
`default_nettype wire
